// [bench/plm_block_tb.sv]
// Testbench: APB configuration and pin-level checks of the macrocell logic block
`timescale 1ns/1ps
module plm_block_tb;
    import plm_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] dedIn = 4'h0;
    logic [15:0] ioIn;
    logic [15:0] ioOut;
    logic [15:0] ioOe;
    logic [15:0] extDrv = 16'hFFFF;
    logic [15:0] fbBus;
    logic [1:0] chainOut;
    logic [1:0] chainIn = 2'h0;
    logic [31:0] rd;
    logic err;
    logic ex;
    int x;
    int errors = 0;
    int checked = 0;
    // Mode, enable, data, second term, expected state after one clock rise
    logic [6:0] seq [14] = '{7'h05, 7'h00, 7'h15, 7'h14, 7'h10, 7'h25, 7'h21,
        7'h26, 7'h22, 7'h35, 7'h31, 7'h36, 7'h0C, 7'h0F};

    always #20 mclk = ~mclk;

    plm_block DUT (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dedIn(dedIn), .ioIn(ioIn), .ioOut(ioOut),
        .ioOe(ioOe), .extFeedback(112'h0), .fbBusOut(fbBus), .chainSumIn(chainIn),
        .chainSumOut(chainOut));

    plm_board board (.ioOut(ioOut), .ioOe(ioOe), .extDrv(extDrv), .ioIn(ioIn));

    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
        int n;
        @(posedge mclk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    // Pins pass a synchroniser, so every change is given time to land
    task automatic pins(input logic [3:0] v);
        @(posedge mclk);
        dedIn <= v;
        repeat (8) @(posedge mclk);
    endtask

    function automatic logic [31:0] cfg1(input logic [2:0] m, input logic ce,
        input logic [1:0] ds);
        return (32'(m) << F_MODE) | (32'(ds) << F_DSEL) | (32'h3 << F_GCK)
            | (32'(ce) << F_CE) | (32'h1 << F_OREG)
            | ((ds == DSEL_PIN) ? 32'h0 : (32'(OE_ON) << F_OE));
    endfunction

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        finish_test();
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        apb(ADDR_SIG, 1'b0, 32'h0);
        chk("sig reset", 32'(SIG_RST), rd);
        apb(12'h010, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        apb(SW_BASE + 12'h004, 1'b1, 32'h1);
        apb(PT_BASE, 1'b1, 32'h1);
        apb(PT_BASE + 12'h010, 1'b1, 32'h2);
        apb(CTL_BASE + 12'h004, 1'b1, 32'h1);
        $display("test reset done");
        // Sum of two terms, then constant and term-driven XOR input
        for (int i = 0; i < 12; i++)
        begin
            x = i / 4;
            apb(CTL_BASE, 1'b1, ((x == 2) ? 32'h1 : 32'h3) | (32'(x) << F_XOR)
                | (32'(OE_ON) << F_OE));
            pins({2'b00, 2'(i)});
            ex = (x == 2) ? (i[0] ^ i[1]) : ((i[0] | i[1]) ^ x[0]);
            chk("comb out", 32'(ex), 32'(ioOut[0]));
            chk("pin level", 32'(ex), 32'(ioIn[0]));
            chk("feedback", 32'(ex), 32'(fbBus[0]));
        end
        apb(ADDR_OE, 1'b0, 32'h0);
        chk("oe reg", 32'h1, rd);
        $display("test sum done");
        apb(PT_BASE + 12'h070, 1'b1, 32'h1);
        apb(PT_BASE + 12'h080, 1'b1, 32'h2);
        apb(PT_BASE + 12'h090, 1'b1, 32'h2);
        apb(CTL_BASE + 12'h00C, 1'b1, 32'h000D40D0);
        foreach (seq[j])
        begin
            apb(CTL_BASE + 12'h008, 1'b1, cfg1(seq[j][6:4], seq[j][3], DSEL_PT));
            pins({2'b00, seq[j][1], seq[j][2]});
            pins({2'b10, seq[j][1], seq[j][2]});
            chk("storage", 32'(seq[j][0]), 32'(ioOut[1]));
            pins({2'b00, seq[j][1], seq[j][2]});
        end
        $display("test modes done");
        apb(CTL_BASE + 12'h008, 1'b1, cfg1(MODE_LATCH, 1'b0, DSEL_PT));
        for (int k = 0; k < 4; k++)
        begin
            pins((k == 0) ? 4'h9 : (k == 1) ? 4'h8 : (k == 2) ? 4'h0 : 4'h1);
            chk("latch", 32'(k == 0), 32'(ioOut[1]));
        end
        $display("test latch done");
        // Preset held on throughout, so any miss of the clear shows as a one
        for (int i = 0; i < 16; i++)
        begin
            x = i / 4;
            apb(CTL_BASE + 12'h008, 1'b1, cfg1(MODE_D, 1'b0, DSEL_PT) | (32'(x) << F_CLR)
                | (32'h2 << F_GCLR) | (32'h1 << F_PRE));
            pins({1'b0, i[1], 1'b1, i[0]});
            ex = (x == 1 && i[1]) || (x == 2 && i[0]) || (x == 3 && (i[0] || i[1]));
            chk("clear", 32'(!ex), 32'(ioOut[1]));
        end
        $display("test clear done");
        apb(CTL_BASE + 12'h008, 1'b1, cfg1(MODE_D, 1'b0, DSEL_PIN));
        for (int k = 1; k >= 0; k--)
        begin
            @(posedge mclk);
            extDrv <= {14'h3FFF, k[0], 1'b1};
            pins(4'h0);
            pins(4'h8);
            chk("pin data", 32'(k), 32'(ioOut[1]));
            chk("input only", 32'h0, 32'(ioOe[1]));
            pins(4'h0);
        end
        $display("test pin data done");
        apb(CTL_BASE, 1'b1, 32'h3 | (32'(OE_ON) << F_OE) | (32'h1 << F_OC));
        for (int k = 0; k < 2; k++)
        begin
            pins({3'b000, k[0]});
            chk("oc enable", 32'(k == 0), 32'(ioOe[0]));
            chk("oc wire", 32'(k), 32'(ioIn[0]));
        end
        $display("test open collector done");
        // Chain of cells 0 to 7 with empty sum masks just passes the head input
        for (int c = 0; c < CHAIN_LEN; c++)
            apb(CTL_BASE + 12'(8 * c), 1'b1, 32'h1 << F_CHAIN);
        for (int v = 0; v < 2; v++)
        begin
            chainIn <= 2'(v);
            @(posedge mclk);
            chk("chain out", 32'(v), 32'(chainOut));
        end
        $display("test chain done");
        apb(ADDR_SIG, 1'b1, 32'h0000A5C3);
        apb(ADDR_LOCK, 1'b1, 32'h1);
        apb(CTL_BASE, 1'b1, 32'hFFFFFFFF);
        apb(CTL_BASE, 1'b0, 32'h0);
        chk("locked ctl", 32'h0, rd);
        apb(ADDR_SIG, 1'b0, 32'h0);
        chk("sig locked", 32'h0000A5C3, rd);
        $display("test lock done");
        finish_test();
    end
endmodule // plm_block_tb

// [bench/plm_board.sv]
// Board-side model of the I/O pins: external drivers and pull-ups
`timescale 1ns/1ps
module plm_board
(
    input wire logic [15:0] ioOut,
    input wire logic [15:0] ioOe,
    input wire logic [15:0] extDrv,
    output logic [15:0] ioIn
);
    // Enabled cell wins the wire; idle lines sit at the board level (pull-up by default)
    assign ioIn = (ioOut & ioOe) | (extDrv & ~ioOe);
endmodule // plm_board

// [core/plm_block.sv]
// Logic block of sixteen macrocells with switch matrix, foldback and APB configuration
//
// How it works
// - Five product terms per cell, all ORable.
// - Allocation mux routes terms to sum, controls.
// - Cascade input joins OR, up to 40.
// - Eight-cell chains give forty-term sums.
// - XOR second input: term, high or low.
// - Constant XOR sets polarity, emulates T/JK.
// - Storage data from XOR, term or pin.
// - D, T, JK, SR and transparent latch.
// - Clock global or term, rising edge only.
// - Low clock enable ignores global clock edges.
// - Clear: global, term, both ORed, or off.
// - Preset: term or off.
// - Output and feedback independently registered/combinational.
// - Per-pin enable from pins, cells, polarity.
// - Input-only pin keeps cell logic usable.
// - Dedicated pins give clock, clear, enable.
// - Global bus: pins plus all feedback.
// - Switch matrix picks forty global signals.
// - Inverted foldback term shared by sixteen cells.
// - Foldback terms build up to 21-term sums.
// - Optional open-collector drive for wired lines.
// - Two-byte signature always readable.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module plm_block
    import plm_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] dedIn,
    input wire logic [15:0] ioIn,
    output logic [15:0] ioOut,
    output logic [15:0] ioOe,
    input wire logic [111:0] extFeedback,
    output logic [15:0] fbBusOut,
    input wire logic [1:0] chainSumIn,
    output logic [1:0] chainSumOut
);
    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    logic [SYNC_W-1:0] s3_r;
    logic [SYNC_W-1:0] lvl_r;
    logic [15:0] fbPipe_r;
    logic [15:0] sig_r;
    logic lock_r;
    logic [31:0] prdata_r;
    logic err_r;
    logic [7:0] swSel_r [0:SW_N-1];
    logic [31:0] ctlA_r [0:CELLS-1];
    logic [31:0] ctlB_r [0:CELLS-1];
    logic [31:0] ptMem [0:PT_WORDS-1];
    logic [SW_N-1:0] swSig;
    logic [CELLS-1:0] foldBus;
    logic [PT_N-1:0] term;
    logic [PT_N-1:0] base;
    logic [CELLS-1:0] cellSum;
    logic [CELLS-1:0] cellOutV;
    logic [CELLS-1:0] cellFb;
    logic [CELLS-1:0] cellState;
    logic [CELLS-1:0] oeRaw;
    logic [31:0] rdVal;

    // Pin inputs: three stages, a change counts once stages two and three agree
    wire [SYNC_W-1:0] pinRaw = {ioIn, dedIn};
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
        end
        else
        begin
            s1_r <= pinRaw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
        end
    end
    wire [3:0] dedLvl = lvl_r[3:0];
    wire [15:0] ioLvl = lvl_r[19:4];

    // Feedback is piped once so no combinational loop runs through the bus
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            fbPipe_r <= '0;
        else
            fbPipe_r <= cellFb;
    end
    assign fbBusOut = fbPipe_r;
    wire [GBUS_W-1:0] gBus = {extFeedback, fbPipe_r, ioLvl, dedLvl};

    genvar s;
    genvar k;
    genvar c;
    generate
        for (s = 0; s < SW_N; s++)
        begin : g_sw
            assign swSig[s] = (swSel_r[s] < 8'(GBUS_W)) ? gBus[swSel_r[s]] : 1'b0;
        end
        for (k = 0; k < PT_N; k++)
        begin : g_pt
            wire [PT_IN-1:0] incl = {ptMem[4*k+1][23:0], ptMem[4*k]};
            wire [PT_IN-1:0] inv = {ptMem[4*k+3][23:0], ptMem[4*k+2]};
            wire [PT_IN-1:0] ptIn = {foldBus, swSig};
            assign term[k] = &(~incl | (ptIn ^ inv));
            // Foldback source sees the switch signals only, breaking the loop
            assign base[k] = &(~incl[SW_N-1:0] | (swSig ^ inv[SW_N-1:0]));
        end
        for (c = 0; c < CELLS; c++)
        begin : g_cell
            wire [2:0] foldIdx = ctlB_r[c][B_FT +: 3];
            wire [4:0] baseC = base[c*TERMS +: TERMS];
            wire chainIn;
            wire [3:0] oeIdx = ctlA_r[c][F_OEIDX +: 4];
            wire [2:0] oeSel = ctlA_r[c][F_OE +: 3];
            wire oc = ctlA_r[c][F_OC];
            assign foldBus[c] = ~((foldIdx < 3'h5) ? baseC[foldIdx] : 1'b0);
            if (c % CHAIN_LEN == 0)
            begin : g_head
                assign chainIn = chainSumIn[c / CHAIN_LEN];
            end
            else
            begin : g_link
                assign chainIn = cellSum[c-1];
            end
            plm_cell u_cell (
                .mclk(mclk),
                .nrst(nrst),
                .terms(term[c*TERMS +: TERMS]),
                .ctlA(ctlA_r[c]),
                .ctlB(ctlB_r[c]),
                .chainIn(chainIn),
                .pinIn(ioLvl[c]),
                .dedIn(dedLvl),
                .sumOut(cellSum[c]),
                .cellOut(cellOutV[c]),
                .fbOut(cellFb[c]),
                .stateOut(cellState[c])
            );
            assign oeRaw[c] = (oeSel == OE_ON) |
                              ((oeSel == OE_DED) & dedLvl[oeIdx[1:0]]) |
                              ((oeSel == OE_DEDN) & ~dedLvl[oeIdx[1:0]]) |
                              ((oeSel == OE_PIN) & ioLvl[oeIdx]) |
                              ((oeSel == OE_CELL) & cellOutV[oeIdx]);
            // Open collector only ever pulls low
            assign ioOe[c] = oeRaw[c] & (~oc | ~cellOutV[c]);
            assign ioOut[c] = ~oc & cellOutV[c];
        end
    endgenerate
    // Input-only pins leave cell, feedback and chain running
    assign chainSumOut = {cellSum[CELLS-1], cellSum[CHAIN_LEN-1]};

    // APB decode: zero wait states, data captured during setup
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite;
    wire isSig = paddr[11:2] == ADDR_SIG[11:2];
    wire isStat = paddr[11:2] == ADDR_STAT[11:2];
    wire isOe = paddr[11:2] == ADDR_OE[11:2];
    wire isLock = paddr[11:2] == ADDR_LOCK[11:2];
    wire isSw = (paddr >= SW_BASE) && (paddr < SW_END);
    wire isCtl = (paddr >= CTL_BASE) && (paddr < CTL_END);
    wire isPt = (paddr >= PT_BASE) && (paddr < PT_END);
    wire mapped = isSig | isStat | isOe | isLock | isSw | isCtl | isPt;
    wire [5:0] swIdx = paddr[7:2];
    wire [3:0] ctlCell = paddr[6:3];
    wire ctlHi = paddr[2];
    wire [8:0] ptIdx = paddr[10:2];
    wire [31:0] cfgVal = isSw ? {24'h000000, swSel_r[swIdx]} :
                         isCtl ? (ctlHi ? ctlB_r[ctlCell] : ctlA_r[ctlCell]) :
                         isPt ? ptMem[ptIdx] : 32'h0000_0000;

    // Lock hides configuration but never the signature
    assign rdVal = isSig ? {16'h0000, sig_r} :
                   isStat ? {cellOutV, cellState} :
                   isOe ? {16'h0000, ioOe} :
                   isLock ? {31'h0000_0000, lock_r} :
                   lock_r ? 32'h0000_0000 : cfgVal;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= mapped ? rdVal : 32'h0000_0000;
            err_r <= ~mapped;
        end
    end
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_r;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sig_r <= SIG_RST;
            lock_r <= 1'b0;
        end
        else if (wr)
        begin
            if (isSig)
                sig_r <= pwdata[15:0];
            if (isLock)
                lock_r <= lock_r | pwdata[0];
        end
    end

    // Configuration arrays; writes are ignored once locked
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < SW_N; i++)
                swSel_r[i] <= SW_RST;
            for (int i = 0; i < CELLS; i++)
            begin
                ctlA_r[i] <= CTL_RST;
                ctlB_r[i] <= CTL_RST;
            end
            for (int i = 0; i < PT_WORDS; i++)
                ptMem[i] <= PT_RST;
        end
        else if (wr && !lock_r)
        begin
            if (isSw)
                swSel_r[swIdx] <= pwdata[7:0];
            if (isCtl && !ctlHi)
                ctlA_r[ctlCell] <= pwdata;
            if (isCtl && ctlHi)
                ctlB_r[ctlCell] <= pwdata;
            if (isPt)
                ptMem[ptIdx] <= pwdata;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    oc_drive_a: assert property (ctlA_r[0][F_OC] && ioOe[0] |-> !ioOut[0])
        else $error("open collector drove high");
    sig_read_a: assert property (setup && !pwrite && isSig |=> prdata[15:0] == $past(sig_r))
        else $error("signature read wrong");
    lock_blank_a: assert property (lock_r && setup && (isCtl || isPt) |=> prdata == 32'h0000_0000)
        else $error("locked config visible");
    fb_pipe_a: assert property (##1 fbBusOut == $past(cellFb))
        else $error("feedback bus lag wrong");
    oe_off_a: assert property (ctlA_r[1][F_OE +: 3] == 3'h0 |-> !ioOe[1])
        else $error("input-only pin driven");

    latch_use_c: cover property (ctlA_r[0][F_MODE +: 3] == MODE_LATCH && cellState[0]);
    chain_use_c: cover property (ctlA_r[1][F_CHAIN] && cellSum[0] && cellSum[1]);
    err_c: cover property (pslverr);
    oc_low_c: cover property (ctlA_r[0][F_OC] && ioOe[0]);
endmodule // plm_block

// [core/plm_cell.sv]
// One macrocell: sum, XOR, storage element and output selection
`timescale 1ns/1ps
module plm_cell
    import plm_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [4:0] terms,
    input wire logic [31:0] ctlA,
    input wire logic [31:0] ctlB,
    input wire logic chainIn,
    input wire logic pinIn,
    input wire logic [3:0] dedIn,
    output logic sumOut,
    output logic cellOut,
    output logic fbOut,
    output logic stateOut
);
    logic q_r;
    logic q_nxt;
    logic clkPrev_r;

    function automatic logic pick(input logic [2:0] i, input logic [4:0] t);
        pick = (i < 3'h5) ? t[i] : 1'b0;
    endfunction

    wire [2:0] mode = ctlA[F_MODE +: 3];
    wire [1:0] xorSel = ctlA[F_XOR +: 2];
    wire [1:0] dSel = ctlA[F_DSEL +: 2];
    wire [1:0] clrSel = ctlA[F_CLR +: 2];
    wire xorIn = (xorSel == XOR_HIGH) | ((xorSel == XOR_PT) & pick(ctlB[B_XT +: 3], terms));
    wire xorOut = sumOut ^ xorIn;
    wire dIn = (dSel == DSEL_PT) ? pick(ctlB[B_DT +: 3], terms) :
               (dSel == DSEL_PIN) ? pinIn : xorOut;
    wire kIn = pick(ctlB[B_KT +: 3], terms);
    wire clkLvl = ctlA[F_CKSEL] ? pick(ctlB[B_CT +: 3], terms) : dedIn[ctlA[F_GCK +: 2]];
    // Enable only applies with the global clock
    wire ceOk = ctlA[F_CKSEL] | ~ctlA[F_CE] | pick(ctlB[B_ET +: 3], terms);
    wire rise = clkLvl & ~clkPrev_r & ceOk;
    wire flow = (mode == MODE_LATCH) & clkLvl & ceOk;
    wire clr = (clrSel[0] & dedIn[ctlA[F_GCLR +: 2]]) |
               (clrSel[1] & pick(ctlB[B_RT +: 3], terms));
    wire pre = ctlA[F_PRE] & pick(ctlB[B_PT +: 3], terms);

    assign sumOut = |(terms & ctlA[F_SUM +: 5]) | (ctlA[F_CHAIN] & chainIn);
    // Clear beats preset when both are asserted
    assign stateOut = clr ? 1'b0 : pre ? 1'b1 : flow ? dIn : q_r;
    assign cellOut = ctlA[F_OREG] ? stateOut : xorOut;
    assign fbOut = ctlA[F_FREG] ? stateOut : xorOut;

    always_comb
    begin
        q_nxt = q_r;
        unique case (mode)
            MODE_D: if (rise) q_nxt = dIn;
            MODE_T: if (rise) q_nxt = q_r ^ dIn;
            MODE_JK: if (rise) q_nxt = (dIn & ~q_r) | (~kIn & q_r);
            MODE_SR: if (rise) q_nxt = kIn ? 1'b0 : (dIn | q_r);
            MODE_LATCH: if (flow) q_nxt = dIn;
            default: q_nxt = q_r;
        endcase
        if (clr)
            q_nxt = 1'b0;
        else if (pre)
            q_nxt = 1'b1;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            q_r <= 1'b0;
            clkPrev_r <= 1'b0;
        end
        else
        begin
            q_r <= q_nxt;
            clkPrev_r <= clkLvl;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    clear_prio_a: assert property (clr |-> !stateOut)
        else $error("clear did not win");
    d_edge_a: assert property ((mode == MODE_D) && rise && !clr && !pre |=> q_r == $past(dIn))
        else $error("D edge not captured");
    ce_hold_a: assert property ((mode != MODE_LATCH) && !rise && !clr && !pre |=> $stable(q_r))
        else $error("state moved without edge");
    toggle_a: assert property ((mode == MODE_T) && rise && dIn && !clr && !pre |=> q_r != $past(q_r))
        else $error("T mode did not toggle");
    preset_set_a: assert property (pre && !clr |=> q_r)
        else $error("preset not applied");
endmodule // plm_cell

// [core/plm_pkg.sv]
// Package: sizes, register map and field layout of the macrocell logic block
package plm_pkg;
    localparam int CELLS = 16;
    localparam int TERMS = 5;
    localparam int DEDS = 4;
    localparam int IOS = 16;
    localparam int EXT_FB = 112;
    localparam int GBUS_W = 148;
    localparam int SW_N = 40;
    localparam int PT_IN = 56;
    localparam int PT_N = 80;
    localparam int PT_WORDS = 320;
    localparam int SYNC_W = 20;
    localparam int CHAIN_LEN = 8;
    localparam int CHAINS = 2;

    localparam logic [11:0] ADDR_SIG = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_OE = 12'h008;
    localparam logic [11:0] ADDR_LOCK = 12'h00C;
    localparam logic [11:0] SW_BASE = 12'h100;
    localparam logic [11:0] SW_END = 12'h1A0;
    localparam logic [11:0] CTL_BASE = 12'h200;
    localparam logic [11:0] CTL_END = 12'h280;
    localparam logic [11:0] PT_BASE = 12'h800;
    localparam logic [11:0] PT_END = 12'hD00;

    localparam logic [15:0] SIG_RST = 16'h0000;
    localparam logic [31:0] CTL_RST = 32'h0000_0000;
    localparam logic [31:0] PT_RST = 32'h0000_0000;
    localparam logic [7:0] SW_RST = 8'h00;

    localparam int F_SUM = 0;
    localparam int F_CHAIN = 5;
    localparam int F_XOR = 6;
    localparam int F_DSEL = 8;
    localparam int F_MODE = 10;
    localparam int F_CKSEL = 13;
    localparam int F_GCK = 14;
    localparam int F_CE = 16;
    localparam int F_CLR = 17;
    localparam int F_GCLR = 19;
    localparam int F_PRE = 21;
    localparam int F_OREG = 22;
    localparam int F_FREG = 23;
    localparam int F_OE = 24;
    localparam int F_OEIDX = 27;
    localparam int F_OC = 31;

    localparam int B_XT = 0;
    localparam int B_DT = 3;
    localparam int B_KT = 6;
    localparam int B_CT = 9;
    localparam int B_ET = 12;
    localparam int B_RT = 15;
    localparam int B_PT = 18;
    localparam int B_FT = 21;

    localparam logic [2:0] MODE_D = 3'h0;
    localparam logic [2:0] MODE_T = 3'h1;
    localparam logic [2:0] MODE_JK = 3'h2;
    localparam logic [2:0] MODE_SR = 3'h3;
    localparam logic [2:0] MODE_LATCH = 3'h4;
    localparam logic [1:0] XOR_HIGH = 2'h1;
    localparam logic [1:0] XOR_PT = 2'h2;
    localparam logic [1:0] DSEL_PT = 2'h1;
    localparam logic [1:0] DSEL_PIN = 2'h2;
    localparam logic [2:0] OE_ON = 3'h1;
    localparam logic [2:0] OE_DED = 3'h2;
    localparam logic [2:0] OE_DEDN = 3'h3;
    localparam logic [2:0] OE_PIN = 3'h4;
    localparam logic [2:0] OE_CELL = 3'h5;
endpackage
